// *** dsp_pkg.sv ***
// Constants, register map and state type for the dual serial port pin block.
// Assumes a 10 MHz mclk and a 32-bit APB register bus.
package dsp_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W      = 8;
  localparam logic [7:0]  OFF_CTL_A   = 8'h00;
  localparam logic [7:0]  OFF_STAT_A  = 8'h04;
  localparam logic [7:0]  OFF_CTL_B   = 8'h08;
  localparam logic [7:0]  OFF_STAT_B  = 8'h0C;
  localparam logic [7:0]  OFF_STRAP   = 8'h10;
  localparam logic [7:0]  PORT_STRIDE = 8'h08;
  // ----------------------------------------------------------------
  // Modem control register fields
  // ----------------------------------------------------------------
  localparam int unsigned CTL_DTR   = 0;
  localparam int unsigned CTL_RTS   = 1;
  localparam int unsigned CTL_TXD   = 2;
  localparam int unsigned CTL_W     = 3;
  localparam logic [2:0]  CTL_RESET = 3'h4;
  // ----------------------------------------------------------------
  // Handshake status register fields
  // ----------------------------------------------------------------
  localparam int unsigned ST_DELTA_LSB = 0;
  localparam int unsigned ST_HS_LSB    = 4;
  localparam int unsigned ST_SIN       = 8;
  localparam int unsigned HS_W         = 4;
  // ----------------------------------------------------------------
  // Synchronised input vector layout
  // ----------------------------------------------------------------
  localparam int unsigned IN_W         = 15;
  localparam int unsigned IN_PER_PORT  = 5;
  localparam int unsigned IN_CTS       = 0;
  localparam int unsigned IN_DSR       = 1;
  localparam int unsigned IN_RI        = 2;
  localparam int unsigned IN_DCD       = 3;
  localparam int unsigned IN_SIN       = 4;
  localparam int unsigned IN_STRAP_LSB = 10;
  // ----------------------------------------------------------------
  // Strap configuration bits
  // ----------------------------------------------------------------
  localparam int unsigned CFG_ADDR_SEL = 0;
  localparam int unsigned CFG_IR_SEL   = 1;
  localparam int unsigned CFG_PNP      = 2;
  localparam int unsigned CFG_GAME_DMA = 3;
  localparam int unsigned CFG_IRQ_GPIO = 4;
  localparam int unsigned CFG_W        = 5;
  localparam logic [31:0] DATA_ZERO    = 32'h0000_0000;
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_LATCH = 2'b01,
    ST_RUN   = 2'b11
  } dsp_state_t;
endpackage

// *** dsp_regbus_if.sv ***
// Internal register strobe bundle between the APB slave and the register file.
// Assumes both ends run on mclk.
`timescale 1ns/1ps
`default_nettype none
interface dsp_regbus_if;
  logic        wr;
  logic        rd;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        hit;
  modport bus  (output wr, rd, addr, wdata, input rdata, hit);
  modport regs (input wr, rd, addr, wdata, output rdata, hit);
endinterface
`default_nettype wire

// *** dsp_sync.sv ***
// Two-stage synchroniser for asynchronous pin inputs.
// Assumes inputs are quasi-static levels relative to mclk.
`timescale 1ns/1ps
`default_nettype none
module dsp_sync #(
  parameter int unsigned W = 1
) (
  input  wire  logic         mclk,
  input  wire  logic [W-1:0] din,
  output var   logic [W-1:0] dout
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] hold_ff;
  // No reset: strap levels must flow through while reset is held
  always_ff @(posedge mclk) begin
    meta_ff <= din;
    hold_ff <= meta_ff;
  end
  assign dout = hold_ff;
endmodule // dsp_sync
`default_nettype wire

// *** dsp_apb_slave.sv ***
// APB slave front end: zero-wait-state, registered read data.
// Assumes the register file answers combinationally on the strobe bundle.
`timescale 1ns/1ps
`default_nettype none
module dsp_apb_slave (
  input  wire  logic        mclk,
  input  wire  logic        rst,
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [7:0]  paddr,
  input  wire  logic [31:0] pwdata,
  output var   logic [31:0] prdata,
  output var   logic        pready,
  output var   logic        pslverr,
  dsp_regbus_if.bus         rb
);
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic        access;
  assign access   = psel & penable;
  assign rb.addr  = paddr;
  assign rb.wdata = pwdata;
  assign rb.wr    = access & pwrite;
  assign rb.rd    = access & ~pwrite;
  assign pready   = 1'b1;
  assign pslverr  = access & ~rb.hit;
  assign prdata   = rdata_ff;
  // Read data captured in the setup cycle so it is stable in access
  always_comb begin
    nxt_rdata = rdata_ff;
    if (psel & ~penable) begin
      nxt_rdata = (~pwrite & rb.hit) ? rb.rdata : dsp_pkg::DATA_ZERO;
    end
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_ff <= dsp_pkg::DATA_ZERO;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end
endmodule // dsp_apb_slave
`default_nettype wire

// *** dsp_serial_pins.sv ***
// Top of the dual serial port pin block: modem lines, serial pins, straps.
// Assumes an APB master on mclk and the modem lines asynchronous to it.
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module dsp_serial_pins (
  input  wire  logic        mclk,
  input  wire  logic        rst,
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [7:0]  paddr,
  input  wire  logic [31:0] pwdata,
  output var   logic [31:0] prdata,
  output var   logic        pready,
  output var   logic        pslverr,
  input  wire  logic        clear_to_send_a,
  input  wire  logic        clear_to_send_b,
  input  wire  logic        set_ready_a,
  input  wire  logic        set_ready_b,
  input  wire  logic        carrier_detect_a,
  input  wire  logic        carrier_detect_b,
  input  wire  logic        ring_in_a,
  input  wire  logic        ring_in_b,
  input  wire  logic        serial_in_a,
  input  wire  logic        serial_in_b,
  input  wire  logic        serial_out_a_i,
  output var   logic        serial_out_a_o,
  output var   logic        serial_out_a_oe,
  input  wire  logic        serial_out_b_i,
  output var   logic        serial_out_b_o,
  output var   logic        serial_out_b_oe,
  input  wire  logic        terminal_ready_a_i,
  output var   logic        terminal_ready_a_o,
  output var   logic        terminal_ready_a_oe,
  output var   logic        terminal_ready_b,
  input  wire  logic        send_request_a_i,
  output var   logic        send_request_a_o,
  output var   logic        send_request_a_oe,
  input  wire  logic        send_request_b_i,
  output var   logic        send_request_b_o,
  output var   logic        send_request_b_oe,
  output var   logic        address_select_bit,
  output var   logic        infrared_select_bit,
  output var   logic        pnp_compat_bit,
  output var   logic        game_dma_select_bit,
  output var   logic        irq_gpio_select_bit
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  dsp_regbus_if rb ();
  logic [dsp_pkg::IN_W-1:0]  rawIn;
  logic [dsp_pkg::IN_W-1:0]  syncIn;
  dsp_pkg::dsp_state_t       state_ff;
  dsp_pkg::dsp_state_t       nxt_state;
  logic [dsp_pkg::CFG_W-1:0] cfg_ff;
  logic [dsp_pkg::CFG_W-1:0] nxt_cfg;
  logic [dsp_pkg::CTL_W-1:0] ctl_ff   [2];
  logic [dsp_pkg::CTL_W-1:0] nxt_ctl  [2];
  logic [dsp_pkg::HS_W-1:0]  hs_ff    [2];
  logic [dsp_pkg::HS_W-1:0]  nxt_hs   [2];
  logic [dsp_pkg::HS_W-1:0]  delta_ff [2];
  logic [dsp_pkg::HS_W-1:0]  nxt_delta[2];
  logic [1:0]                sin_ff;
  logic [1:0]                nxt_sin;
  logic [31:0]               statWord [2];
  logic [5:0]                pinO_ff;
  logic [5:0]                nxt_pinO;
  logic                      drive_ff;
  logic                      nxt_drive;
  logic                      irTxd;
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  assign rawIn = {send_request_b_i, serial_out_b_i, send_request_a_i,
                  serial_out_a_i, terminal_ready_a_i,
                  serial_in_b, carrier_detect_b, ring_in_b, set_ready_b,
                  clear_to_send_b,
                  serial_in_a, carrier_detect_a, ring_in_a, set_ready_a,
                  clear_to_send_a};
  dsp_sync #(.W(dsp_pkg::IN_W)) u_sync (
    .mclk (mclk),
    .din  (rawIn),
    .dout (syncIn)
  );
  dsp_apb_slave u_apb (
    .mclk    (mclk),
    .rst     (rst),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .rb      (rb)
  );
  // ----------------------------------------------------------------
  // Reset sequencer and strap capture
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_cfg   = cfg_ff;
    case (state_ff)
      dsp_pkg::ST_RESET: begin
        nxt_state = dsp_pkg::ST_LATCH;
      end
      dsp_pkg::ST_LATCH: begin
        // Pins still released; synced levels date from reset time
        nxt_cfg   = syncIn[dsp_pkg::IN_STRAP_LSB +: dsp_pkg::CFG_W];
        nxt_state = dsp_pkg::ST_RUN;
      end
      dsp_pkg::ST_RUN: begin
        if (rb.wr && rb.addr == dsp_pkg::OFF_STRAP) begin
          nxt_cfg = rb.wdata[dsp_pkg::CFG_W-1:0];
        end
      end
      default: begin
        nxt_state = dsp_pkg::ST_RESET;
      end
    endcase
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_ff <= dsp_pkg::ST_RESET;
      cfg_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      cfg_ff   <= nxt_cfg;
    end
  end
  // ----------------------------------------------------------------
  // Per-port modem control and handshake status
  // ----------------------------------------------------------------
  for (genvar p = 0; p < 2; p++) begin : g_port
    localparam int unsigned BASE = p * dsp_pkg::IN_PER_PORT;
    localparam logic [7:0] CTL_OFF = dsp_pkg::OFF_CTL_A + 8'(p) * dsp_pkg::PORT_STRIDE;
    localparam logic [7:0] ST_OFF = dsp_pkg::OFF_STAT_A + 8'(p) * dsp_pkg::PORT_STRIDE;
    logic [dsp_pkg::HS_W-1:0] hsNow;
    // Active-low pins seen as asserted-high flags
    assign hsNow = ~{syncIn[BASE + dsp_pkg::IN_DCD],
                     syncIn[BASE + dsp_pkg::IN_RI],
                     syncIn[BASE + dsp_pkg::IN_DSR],
                     syncIn[BASE + dsp_pkg::IN_CTS]};
    assign statWord[p] = {23'h00_0000, sin_ff[p], hs_ff[p], delta_ff[p]};
    always_comb begin
      nxt_ctl[p]   = ctl_ff[p];
      nxt_hs[p]    = hsNow;
      nxt_delta[p] = delta_ff[p];
      nxt_sin[p]   = syncIn[BASE + dsp_pkg::IN_SIN];
      if (rb.wr && rb.addr == CTL_OFF) begin
        nxt_ctl[p] = rb.wdata[dsp_pkg::CTL_W-1:0];
      end
      // Clear only the flags that the captured read word reported
      if (rb.rd && rb.addr == ST_OFF) begin
        nxt_delta[p] = delta_ff[p] & ~prdata[dsp_pkg::ST_DELTA_LSB +: dsp_pkg::HS_W];
      end
      // A change in the clearing cycle still sets its flag
      nxt_delta[p] = nxt_delta[p] | (hsNow ^ hs_ff[p]);
    end
    always_ff @(posedge mclk) begin
      if (rst) begin
        ctl_ff[p]   <= dsp_pkg::CTL_RESET;
        hs_ff[p]    <= '0;
        delta_ff[p] <= '0;
        sin_ff[p]   <= 1'b1;
      end else begin
        ctl_ff[p]   <= nxt_ctl[p];
        hs_ff[p]    <= nxt_hs[p];
        delta_ff[p] <= nxt_delta[p];
        sin_ff[p]   <= nxt_sin[p];
      end
    end
  end
  // ----------------------------------------------------------------
  // Register read mux
  // ----------------------------------------------------------------
  always_comb begin
    rb.hit   = 1'b1;
    rb.rdata = dsp_pkg::DATA_ZERO;
    case (rb.addr)
      dsp_pkg::OFF_CTL_A:  rb.rdata = {29'h0000_0000, ctl_ff[0]};
      dsp_pkg::OFF_STAT_A: rb.rdata = statWord[0];
      dsp_pkg::OFF_CTL_B:  rb.rdata = {29'h0000_0000, ctl_ff[1]};
      dsp_pkg::OFF_STAT_B: rb.rdata = statWord[1];
      dsp_pkg::OFF_STRAP:  rb.rdata = {27'h000_0000, cfg_ff};
      default:             rb.hit   = 1'b0;
    endcase
  end
  // ----------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------
  // Infrared mode idles the shared port B transmitter low
  assign irTxd = cfg_ff[dsp_pkg::CFG_IR_SEL] ? ~ctl_ff[1][dsp_pkg::CTL_TXD]
                                             : ctl_ff[1][dsp_pkg::CTL_TXD];
  always_comb begin
    nxt_drive = (state_ff == dsp_pkg::ST_RUN);
    nxt_pinO  = {~ctl_ff[1][dsp_pkg::CTL_DTR],
                 ~ctl_ff[1][dsp_pkg::CTL_RTS],
                 ~ctl_ff[0][dsp_pkg::CTL_RTS],
                 ~ctl_ff[0][dsp_pkg::CTL_DTR],
                 irTxd,
                 ctl_ff[0][dsp_pkg::CTL_TXD]};
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      drive_ff <= 1'b0;
      pinO_ff  <= 6'h3F;
    end else begin
      drive_ff <= nxt_drive;
      pinO_ff  <= nxt_pinO;
    end
  end
  assign serial_out_a_o      = pinO_ff[0];
  assign serial_out_b_o      = pinO_ff[1];
  assign terminal_ready_a_o  = pinO_ff[2];
  assign send_request_a_o    = pinO_ff[3];
  assign send_request_b_o    = pinO_ff[4];
  assign terminal_ready_b    = pinO_ff[5];
  assign serial_out_a_oe     = drive_ff;
  assign serial_out_b_oe     = drive_ff;
  assign terminal_ready_a_oe = drive_ff;
  assign send_request_a_oe   = drive_ff;
  assign send_request_b_oe   = drive_ff;
  assign address_select_bit  = cfg_ff[dsp_pkg::CFG_ADDR_SEL];
  assign infrared_select_bit = cfg_ff[dsp_pkg::CFG_IR_SEL];
  assign pnp_compat_bit      = cfg_ff[dsp_pkg::CFG_PNP];
  assign game_dma_select_bit = cfg_ff[dsp_pkg::CFG_GAME_DMA];
  assign irq_gpio_select_bit = cfg_ff[dsp_pkg::CFG_IRQ_GPIO];
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  strap_undriven_a: assert property ($past(rst) |-> !serial_out_a_oe && !send_request_b_oe)
    else $error("strap pin driven too soon after reset");
  strap_capture_a: assert property (state_ff == dsp_pkg::ST_LATCH |=> cfg_ff == $past(syncIn[14:10]))
    else $error("strap levels not captured at release");
  strap_addr_a: assert property (state_ff == dsp_pkg::ST_LATCH |=> address_select_bit == $past(syncIn[10]))
    else $error("address select not taken from terminal ready a");
  strap_irq_a: assert property (state_ff == dsp_pkg::ST_LATCH |=> irq_gpio_select_bit == $past(syncIn[14]))
    else $error("irq select not taken from send request b");
  cts_status_a: assert property (!$past(rst) |-> hs_ff[0][0] == !$past(syncIn[0]))
    else $error("clear to send status wrong");
  dsr_status_a: assert property (!$past(rst) |-> hs_ff[1][1] == !$past(syncIn[6]))
    else $error("set ready status wrong");
  delta_set_a: assert property (hs_ff[0] != $past(hs_ff[0]) |->
    (delta_ff[0] & ($past(hs_ff[0]) ^ hs_ff[0])) == ($past(hs_ff[0]) ^ hs_ff[0]))
    else $error("handshake delta lost");
  dtr_drive_a: assert property (drive_ff |-> terminal_ready_a_o == !$past(ctl_ff[0][0]))
    else $error("terminal ready a level wrong");
  rts_drive_a: assert property (state_ff == dsp_pkg::ST_RUN ##1 1 |-> send_request_b_o == !$past(ctl_ff[1][1]))
    else $error("send request b level wrong");
  txd_drive_a: assert property (state_ff == dsp_pkg::ST_RUN ##1 1 |-> serial_out_a_o == $past(ctl_ff[0][2]))
    else $error("serial out a level wrong");
  sin_follow_a: assert property (!$past(rst) |-> sin_ff[1] == $past(syncIn[9]))
    else $error("serial in b not sampled");
  run_cover: cover property (state_ff == dsp_pkg::ST_LATCH ##1 state_ff == dsp_pkg::ST_RUN);
  ring_cover: cover property (delta_ff[0][2] ##1 !delta_ff[0][2]);
  ir_cover: cover property (infrared_select_bit && serial_out_b_oe);
endmodule // dsp_serial_pins
`default_nettype wire

// *** dsp_modem_model.sv ***
// Far-side model: modem handshake lines and the board's strap resistors.
// Assumes the bench sets modem levels and strap overrides; pin levels are resolved here.
`timescale 1ns/1ps
`default_nettype none
module dsp_modem_model (
  input  wire logic [3:0] hsA,
  input  wire logic [3:0] hsB,
  input  wire logic       serInA,
  input  wire logic       serInB,
  input  wire logic [4:0] strapExt,
  input  wire logic [4:0] strapUse,
  input  wire logic [4:0] pinO,
  input  wire logic [4:0] pinOe,
  output var  logic [3:0] lineA,
  output var  logic [3:0] lineB,
  output var  logic       rxA,
  output var  logic       rxB,
  output var  logic [4:0] pinLvl
);
  // ----------------------------------------------------------------
  // Pin resolution
  // ----------------------------------------------------------------
  // Internal pulls: terminal-ready A down, serial outs up, send-request A up, B down
  localparam logic [4:0] PULL = 5'h0e;

  // Lines are levels, low means asserted
  assign lineA = hsA;
  assign lineB = hsB;
  assign rxA   = serInA;
  assign rxB   = serInB;

  // A released pin falls to the external resistor if fitted, else to its pull
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      pinLvl[i] = pinOe[i] ? pinO[i] : (strapUse[i] ? strapExt[i] : PULL[i]);
    end
  end
endmodule // dsp_modem_model
`default_nettype wire

// *** dsp_serial_pins_tb.sv ***
// Self-checking bench for the dual serial port pin block.
// Assumes the package, interface, design modules and modem model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module dsp_serial_pins_tb;
  logic        mclk     = 1'b0;
  logic        rst      = 1'b1;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0000_0000;
  logic [3:0]  hsA      = 4'hf;
  logic [3:0]  hsB      = 4'hf;
  logic        serInA   = 1'b1;
  logic        serInB   = 1'b1;
  logic [4:0]  strapExt = 5'h00;
  logic [4:0]  strapUse = 5'h00;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [4:0]  pinO;
  logic [4:0]  pinOe;
  logic [4:0]  pinLvl;
  logic [4:0]  cfgBits;
  logic [4:0]  cfgExp;
  logic [3:0]  mdmA;
  logic [3:0]  mdmB;
  logic        mSinA;
  logic        mSinB;
  logic        termReadyB;
  int          errCount = 0;
  int          nChecks  = 0;
  localparam logic [4:0] PULL = 5'h0e;

  always #50 mclk = ~mclk;

  dsp_modem_model mdm_u (.hsA(hsA), .hsB(hsB), .serInA(serInA), .serInB(serInB), .strapExt(strapExt),
    .strapUse(strapUse), .pinO(pinO), .pinOe(pinOe), .lineA(mdmA), .lineB(mdmB), .rxA(mSinA),
    .rxB(mSinB), .pinLvl(pinLvl));

  dsp_serial_pins dut_u (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .clear_to_send_a(mdmA[0]), .clear_to_send_b(mdmB[0]), .set_ready_a(mdmA[1]), .set_ready_b(mdmB[1]),
    .ring_in_a(mdmA[2]), .ring_in_b(mdmB[2]), .carrier_detect_a(mdmA[3]), .carrier_detect_b(mdmB[3]),
    .serial_in_a(mSinA), .serial_in_b(mSinB),
    .serial_out_a_i(pinLvl[1]), .serial_out_a_o(pinO[1]), .serial_out_a_oe(pinOe[1]),
    .serial_out_b_i(pinLvl[3]), .serial_out_b_o(pinO[3]), .serial_out_b_oe(pinOe[3]),
    .terminal_ready_a_i(pinLvl[0]), .terminal_ready_a_o(pinO[0]), .terminal_ready_a_oe(pinOe[0]),
    .terminal_ready_b(termReadyB),
    .send_request_a_i(pinLvl[2]), .send_request_a_o(pinO[2]), .send_request_a_oe(pinOe[2]),
    .send_request_b_i(pinLvl[4]), .send_request_b_o(pinO[4]), .send_request_b_oe(pinOe[4]),
    .address_select_bit(cfgBits[0]), .infrared_select_bit(cfgBits[1]), .pnp_compat_bit(cfgBits[2]),
    .game_dma_select_bit(cfgBits[3]), .irq_gpio_select_bit(cfgBits[4]));

  // ----------------------------------------------------------------
  // Expectations and reporting
  // ----------------------------------------------------------------
  function automatic logic [31:0] exp_status(logic [3:0] hs, logic sin, logic [3:0] prevHs);
    return {23'h0, sin, ~hs, prevHs ^ hs};
  endfunction

  function automatic logic [2:0] exp_pins(logic [2:0] c, logic inv);
    return {~c[0], ~c[1], c[2] ^ inv};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // APB master
  // ----------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int i;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      errCount++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp, input logic expErr);
    logic [31:0] d;
    logic        e;
    apb(1'b0, addr, 32'h0000_0000, d, e);
    check(d, exp);
    check({31'h0, e}, {31'h0, expErr});
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] wd, input logic expErr);
    logic [31:0] d;
    logic        e;
    apb(1'b1, addr, wd, d, e);
    check({31'h0, e}, {31'h0, expErr});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic do_reset(input logic [4:0] useMask, input logic [4:0] extLvl);
    logic [4:0] exp;
    exp = (useMask & extLvl) | (~useMask & PULL);
    @(posedge mclk);
    strapUse <= useMask;
    strapExt <= extLvl;
    rst      <= 1'b1;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    check({27'h0, pinOe}, 32'h0000_0000);
    check({27'h0, pinLvl}, {27'h0, exp});
    @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    check({27'h0, cfgBits}, {27'h0, exp});
    @(posedge mclk);
    @(negedge mclk);
    check({27'h0, pinOe}, 32'h0000_001f);
    cfgExp = exp;
    rd_chk(dsp_pkg::OFF_STRAP, {27'h0, exp}, 1'b0);
  endtask

  task automatic ctl_port(input logic p, input logic [2:0] c);
    logic [7:0] a;
    a = p ? dsp_pkg::OFF_CTL_B : dsp_pkg::OFF_CTL_A;
    wr(a, {29'($urandom), c}, 1'b0);
    @(posedge mclk);
    @(negedge mclk);
    if (p) check({29'h0, termReadyB, pinLvl[4], pinLvl[3]}, {29'h0, exp_pins(c, cfgExp[1])});
    else check({29'h0, pinLvl[0], pinLvl[2], pinLvl[1]}, {29'h0, exp_pins(c, 1'b0)});
    rd_chk(a, {29'h0, c}, 1'b0);
  endtask

  initial begin
    logic [3:0] nA;
    logic [3:0] nB;
    logic [3:0] prevA;
    logic [3:0] prevB;
    logic       sA;
    logic       sB;
    int         n;
    void'($urandom(32'hb8d93d4d));
    do_reset(5'h00, 5'h00);
    do_reset(5'h1f, 5'h00);
    do_reset(5'h1f, 5'h1f);
    for (n = 0; n < 4; n++) do_reset(5'($urandom), 5'($urandom));
    rd_chk(dsp_pkg::OFF_CTL_A, 32'h0000_0004, 1'b0);
    rd_chk(dsp_pkg::OFF_CTL_B, 32'h0000_0004, 1'b0);
    // Control pins in both infrared modes, both ports
    for (n = 0; n < 16; n++) begin
      if (n == 0 || n == 8) begin
        cfgExp = {5'($urandom) & 5'h1d} | {3'h0, (n == 8), 1'b0};
        wr(dsp_pkg::OFF_STRAP, {27'h7ff_ffff, cfgExp}, 1'b0);
        rd_chk(dsp_pkg::OFF_STRAP, {27'h0, cfgExp}, 1'b0);
      end
      ctl_port(n[0], (n < 2) ? 3'h3 : 3'($urandom));
    end
    // Unmapped places refuse and leave the strap register alone
    rd_chk(8'h14, 32'h0000_0000, 1'b1);
    rd_chk(8'hfc, 32'h0000_0000, 1'b1);
    wr(8'h14, 32'hffff_ffff, 1'b1);
    rd_chk(dsp_pkg::OFF_STRAP, {27'h0, cfgExp}, 1'b0);
    // Modem lines and serial inputs, deltas cleared by each read
    prevA = 4'hf;
    prevB = 4'hf;
    for (n = 0; n < 12; n++) begin
      nA = (n == 0) ? 4'h0 : 4'($urandom);
      nB = (n == 1) ? 4'h0 : 4'($urandom);
      sA = 1'($urandom);
      sB = (n < 4) ? ~sA : 1'($urandom);
      @(posedge mclk);
      hsA  <= nA;
      hsB  <= nB;
      serInA <= sA;
      serInB <= sB;
      repeat (5) @(posedge mclk);
      rd_chk(dsp_pkg::OFF_STAT_A, exp_status(nA, sA, prevA), 1'b0);
      rd_chk(dsp_pkg::OFF_STAT_B, exp_status(nB, sB, prevB), 1'b0);
      prevA = nA;
      prevB = nB;
    end
    final_report();
  end
endmodule // dsp_serial_pins_tb
`default_nettype wire
